/* core/bbfc_consts.vh */
/*
 constants for the boot-block flash bus controller: command bytes,
 operation codes and pin timing counts. assumes a 200 mhz clock.
*/
`ifndef BBFC_CONSTS_VH
`define BBFC_CONSTS_VH

`define BBFC_CMD_ERASE_SETUP 8'h20
`define BBFC_CMD_ERASE_CONFIRM 8'hd0
`define BBFC_CMD_WRITE_SETUP 8'h40
`define BBFC_CMD_READ_ARRAY 8'hff
`define BBFC_CMD_IDENTIFY 8'h90

`define BBFC_OP_READ 3'h0
`define BBFC_OP_ERASE 3'h1
`define BBFC_OP_PROGRAM 3'h2
`define BBFC_OP_READ_ARRAY 3'h3
`define BBFC_OP_ID_CMD 3'h4
`define BBFC_OP_ID_HV 3'h5
`define BBFC_OP_RAW_CMD 3'h6

`define BBFC_CLK_MHZ 200
`define BBFC_STROBE_NS 60
`define BBFC_SETTLE_NS 30
`define BBFC_READ_NS 100
`define BBFC_STROBE_CYC ((`BBFC_STROBE_NS * `BBFC_CLK_MHZ + 999) / 1000)
`define BBFC_SETTLE_CYC ((`BBFC_SETTLE_NS * `BBFC_CLK_MHZ + 999) / 1000)
`define BBFC_READ_CYC ((`BBFC_READ_NS * `BBFC_CLK_MHZ + 999) / 1000)

`endif

/* core/bbfc_sync.v */
/*
 two flip-flop synchroniser for a bus of pin inputs.
 assumes the inputs are asynchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module bbfc_sync #(
    parameter W = 16
) (
    // clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    // data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

/* core/bbfc_ctrl.v */
/*
 host-side controller for an asynchronous boot-block flash memory.
 it sequences the device pins for reads, erase and program sequences,
 read-array and identification. assumes the board turns the unlock
 and identify enables into the 12v levels on the reset and a9 pins.
*/
// Functional notes
// R1: erase sends 20h then d0h with vpp
// R2: program sends 40h setup then data cycle
// R3: read-array ffh needed before array reads
// R4: id values at a9 high voltage or command
// R5: boot block needs unlock level or protect
// R6: high-voltage id holds other addresses low
// R7: erase affects only the addressed block
// R8: device engine sequences program and erase itself
// R9: device engine guards against over-erasure
// R10: chip enable high deselects, outputs float
// R11: reset pin low clears and floats device
// R12: byte mode uses low byte, dq15 address; the controller leaves dq15 undriven on reads
// R13: device drives data only with oe low
// R14: read with we high; write pulses we
// R15: orphan confirm or data cycle is invalid
`timescale 1ns/10ps
`include "bbfc_consts.vh"
module bbfc_ctrl #(
    parameter AW = 17,
    parameter STROBE_CYC = `BBFC_STROBE_CYC,
    parameter SETTLE_CYC = `BBFC_SETTLE_CYC,
    parameter READ_CYC = `BBFC_READ_CYC
) (
    // clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    // user request
    input wire req_valid_i,
    output wire req_ready_o,
    input wire [2:0] req_op_i,
    input wire [AW-1:0] req_addr_i,
    input wire [15:0] req_data_i,
    input wire req_byte_mode_i,
    input wire req_boot_unlock_i,
    input wire req_write_protect_off_i,
    // user answer
    output reg rsp_valid_o,
    output reg [15:0] rsp_data_o,
    output wire busy_o,
    // flash control pins
    output reg flash_ce_n_o,
    output reg flash_oe_n_o,
    output reg flash_we_n_o,
    output reg reset_powerdown_pin_n_o,
    output reg unlock_hv_en_o,
    output reg write_protect_off_o,
    output reg byte_mode_n_o,
    output reg vpp_en_o,
    output reg identify_super_voltage_en_o,
    output reg [AW-1:0] flash_addr_o,
    // flash data pins
    input wire [15:0] flash_dq_i,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe_o
);
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_STROBE = 3'h2;
    localparam S_RECOVER = 3'h3;
    localparam S_READ = 3'h4;
    localparam S_DONE = 3'h5;

    reg [2:0] state_q;
    reg [2:0] op_q;
    reg [1:0] phase_q;
    reg [7:0] cnt_q;
    reg [15:0] data_q;
    reg [15:0] wdata;
    wire [15:0] dq_sync;
    wire last_phase;

    bbfc_sync #(
        .W(16)
    ) u_dq_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(flash_dq_i),
        .q_o(dq_sync)
    );

    assign req_ready_o = (state_q == S_IDLE);
    assign busy_o = (state_q != S_IDLE);
    // two-cycle ops stop after phase 1, single commands after phase 0
    assign last_phase = ((op_q == `BBFC_OP_ERASE) || (op_q == `BBFC_OP_PROGRAM)) ?
                        (phase_q == 2'h1) : 1'b1;

    always @* begin
        wdata = {8'h00, `BBFC_CMD_READ_ARRAY};
        case (op_q)
            `BBFC_OP_ERASE: wdata = (phase_q == 2'h0) ? {8'h00, `BBFC_CMD_ERASE_SETUP} :
                                    {8'h00, `BBFC_CMD_ERASE_CONFIRM}; // R1
            `BBFC_OP_PROGRAM: wdata = (phase_q == 2'h0) ? {8'h00, `BBFC_CMD_WRITE_SETUP} :
                                      data_q; // R2
            `BBFC_OP_READ_ARRAY: wdata = {8'h00, `BBFC_CMD_READ_ARRAY}; // R3
            `BBFC_OP_ID_CMD: wdata = {8'h00, `BBFC_CMD_IDENTIFY}; // R4
            `BBFC_OP_RAW_CMD: wdata = data_q;
            default: wdata = {8'h00, `BBFC_CMD_READ_ARRAY};
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            op_q <= 3'h0;
            phase_q <= 2'h0;
            cnt_q <= 8'h00;
            data_q <= 16'h0000;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 16'h0000;
            flash_ce_n_o <= 1'b1; // R10
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            reset_powerdown_pin_n_o <= 1'b0; // R11
            unlock_hv_en_o <= 1'b0;
            write_protect_off_o <= 1'b0;
            byte_mode_n_o <= 1'b1;
            vpp_en_o <= 1'b0;
            identify_super_voltage_en_o <= 1'b0;
            flash_addr_o <= {AW{1'b0}};
            flash_dq_o <= 16'h0000;
            flash_dq_oe_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            reset_powerdown_pin_n_o <= 1'b1;
            case (state_q)
                S_IDLE: begin
                    if (req_valid_i) begin
                        op_q <= req_op_i;
                        data_q <= req_data_i;
                        phase_q <= 2'h0;
                        cnt_q <= 8'h00;
                        byte_mode_n_o <= ~req_byte_mode_i; // R12
                        flash_ce_n_o <= 1'b0;
                        if (req_op_i == `BBFC_OP_ID_HV) begin
                            flash_addr_o <= {AW{1'b0}}; // R6
                            flash_addr_o[0] <= req_addr_i[0]; // R4
                            identify_super_voltage_en_o <= 1'b1; // R4
                        end else begin
                            flash_addr_o <= req_addr_i; // R7
                        end
                        if (req_op_i == `BBFC_OP_READ || req_op_i == `BBFC_OP_ID_HV) begin
                            state_q <= S_READ;
                        end else begin
                            unlock_hv_en_o <= req_boot_unlock_i; // R5
                            write_protect_off_o <= req_write_protect_off_i; // R5
                            state_q <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    // oe stays high so device and host never drive together
                    flash_oe_n_o <= 1'b1; // R14
                    flash_dq_o <= wdata;
                    flash_dq_oe_o <= 1'b1;
                    vpp_en_o <= (phase_q == 2'h1); // R1
                    if (cnt_q >= SETTLE_CYC - 1) begin
                        cnt_q <= 8'h00;
                        flash_we_n_o <= 1'b0; // R14
                        state_q <= S_STROBE;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_STROBE: begin
                    if (cnt_q >= STROBE_CYC - 1) begin
                        cnt_q <= 8'h00;
                        flash_we_n_o <= 1'b1;
                        state_q <= S_RECOVER;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_RECOVER: begin
                    if (cnt_q >= SETTLE_CYC - 1) begin
                        cnt_q <= 8'h00;
                        if (last_phase) begin
                            flash_dq_oe_o <= 1'b0;
                            state_q <= S_DONE;
                        end else begin
                            phase_q <= phase_q + 2'h1; // R15
                            state_q <= S_SETUP;
                        end
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_READ: begin
                    flash_we_n_o <= 1'b1; // R14
                    flash_oe_n_o <= 1'b0; // R13
                    flash_dq_oe_o <= 1'b0;
                    if (cnt_q >= READ_CYC + 1) begin
                        // two extra cycles cover the data synchroniser
                        cnt_q <= 8'h00;
                        rsp_data_o <= byte_mode_n_o ? dq_sync : {8'h00, dq_sync[7:0]}; // R12
                        rsp_valid_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        state_q <= S_DONE;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_DONE: begin
                    // supplies drop with chip enable; a slow engine needs software to hold off
                    flash_ce_n_o <= 1'b1; // R8
                    flash_oe_n_o <= 1'b1;
                    vpp_en_o <= 1'b0;
                    unlock_hv_en_o <= 1'b0;
                    write_protect_off_o <= 1'b0;
                    identify_super_voltage_en_o <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* tb/bbfc_flash_model.sv */
/* behavioural boot-block flash: small array, command decoder, id and status reads.
 assumes the host still drives dq at the rising edge of its write strobe. */
`timescale 1ns/10ps
module bbfc_flash_model #(
    parameter [7:0] MAN_ID = 8'h5a, // arbitrary value
    parameter [7:0] DEV_ID = 8'ha5 // arbitrary value
) (
    input wire ce_n, oe_n, we_n, pd_n, hh, wp, byte_n, vpp, idv,
    input wire [16:0] a,
    input wire [15:0] din,
    output wire [15:0] dq
);
    reg [15:0] mem [0:15];
    reg [15:0] last = 0;
    reg [7:0] su = 0;
    reg [1:0] md = 0;
    integer i;
    wire [3:0] ix = {a[16], a[2:0]};
    wire ok = !a[16] || hh || wp;
    wire on = pd_n && !ce_n && !oe_n;
    wire [15:0] idw = {8'h00, a[0] ? DEV_ID : MAN_ID};
    wire [15:0] v = (idv || md == 1) ? idw : (md == 2 ? 16'h0080 : mem[ix]);
    // a released bus shows the inverse of its last value, not a fixed zero
    assign dq = on ? (byte_n ? v : {~last[15:8], v[7:0]}) : ~last;
    initial for (i = 0; i < 16; i++) mem[i] = i * 16'h0101;
    always @(v or on) if (on) last = v;
    always @(negedge pd_n) begin md = 0; su = 0; end
    always @(posedge we_n) if (!ce_n && pd_n) begin
        if (su == 8'h20) begin
            if (din[7:0] == 8'hd0 && vpp && ok)
                for (i = 0; i < 8; i++) mem[{a[16], i[2:0]}] = 16'hffff;
            md = 2; su = 0;
        end else if (su == 8'h40 || su == 8'h10) begin
            if (vpp && ok) mem[ix] = mem[ix] & din;
            md = 2; su = 0;
        end else begin
            su = din[7:0];
            md = su == 8'hff ? 2'd0 : (su == 8'h90 ? 2'd1 : md);
        end
    end
endmodule

/* tb/bbfc_ctrl_sva.sv */
/* pin sequencing checker for bbfc_ctrl.
 assumes the default timing parameters and one clock domain. */
`timescale 1ns/10ps
module bbfc_ctrl_sva (
    input wire ref_clk_i, nrst_i, req_valid_i, req_ready_o, rsp_valid_o,
    input wire flash_ce_n_o, flash_oe_n_o, flash_we_n_o, reset_powerdown_pin_n_o,
    input wire vpp_en_o, identify_super_voltage_en_o, flash_dq_oe_o,
    input wire [2:0] req_op_i,
    input wire [16:0] flash_addr_o
);
    reg we_q, plain_q;
    always @(posedge ref_clk_i) begin
        we_q <= flash_we_n_o;
        if (!nrst_i) plain_q <= 1'b0;
        else if (we_q && !flash_we_n_o) plain_q <= !vpp_en_o;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_read_only_sel: assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o
        && !flash_dq_oe_o) else $error("oe low outside a clean read");
    a_write_strobe_ok: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o
        && flash_dq_oe_o) else $error("we low outside a driven write");
    a_strobe_width: assert property ($fell(flash_we_n_o) |-> ##11 !flash_we_n_o
        ##1 flash_we_n_o) else $error("write strobe width wrong");
    a_setup_first: assert property (we_q && !flash_we_n_o && vpp_en_o |-> plain_q)
        else $error("supplied cycle without setup cycle");
    a_reset_pins: assert property (disable iff (1'b0) !nrst_i ##1 !nrst_i |-> flash_ce_n_o
        && !reset_powerdown_pin_n_o && !flash_dq_oe_o && !vpp_en_o) else $error("reset pins");
    a_read_answer: assert property (req_valid_i && req_ready_o && req_op_i == 3'h0
        |-> ##23 rsp_valid_o) else $error("read answer late or missing");
    a_hv_addr_low: assert property (identify_super_voltage_en_o && !flash_oe_n_o
        |-> flash_addr_o[16:10] == 7'h0 && flash_addr_o[8:1] == 8'h0) else $error("id address");
    a_vpp_in_write: assert property (vpp_en_o |-> flash_oe_n_o && !flash_ce_n_o)
        else $error("program supply outside a write");
endmodule
bind bbfc_ctrl bbfc_ctrl_sva u_sva (.*);

/* tb/test_boot_block_flash_bus_commands.sv */
/* self-checking bench for bbfc_ctrl against the behavioural flash.
 assumes the controller's default timing parameters. */
`timescale 1ns/10ps
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin bad_count++; \
    $display("[ERR] %0t %h %h", $time, x, y); end end
module test_boot_block_flash_bus_commands;
    localparam [7:0] MAN = 8'h5a, DEV = 8'ha5; // arbitrary id values
    reg ref_clk_i = 0, nrst_i = 0, vld = 0;
    reg [2:0] op_q = 0, cfg = 0, g = 0;
    reg [16:0] ad = 0, a, b;
    reg [15:0] dt = 0, rd;
    reg [15:0] sh [0:15];
    integer bad_count = 0, checks_done = 0, i, k;
    wire rdy, rv, bsy, ce_n, oe_n, we_n, pd_n, hh, wp, bn, vpp, idv, doe;
    wire [16:0] fa;
    wire [15:0] rdat, dqo, mdq;
    wire [15:0] dq = doe ? dqo : mdq;
    always #2.5 ref_clk_i = ~ref_clk_i;
    bbfc_ctrl dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_valid_i(vld), .req_ready_o(rdy),
        .req_op_i(op_q), .req_addr_i(ad), .req_data_i(dt), .req_byte_mode_i(cfg[2]),
        .req_boot_unlock_i(cfg[1]), .req_write_protect_off_i(cfg[0]), .rsp_valid_o(rv),
        .rsp_data_o(rdat), .busy_o(bsy), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
        .flash_we_n_o(we_n), .reset_powerdown_pin_n_o(pd_n), .unlock_hv_en_o(hh),
        .write_protect_off_o(wp), .byte_mode_n_o(bn), .vpp_en_o(vpp),
        .identify_super_voltage_en_o(idv), .flash_addr_o(fa), .flash_dq_i(dq),
        .flash_dq_o(dqo), .flash_dq_oe_o(doe));
    bbfc_flash_model #(.MAN_ID(MAN), .DEV_ID(DEV)) fm (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .pd_n(pd_n), .hh(hh), .wp(wp), .byte_n(bn), .vpp(vpp), .idv(idv), .a(fa), .din(dq),
        .dq(mdq));
    function [15:0] ex(input [16:0] x);
        ex = sh[{x[16], x[2:0]}];
    endfunction
    task op(input [2:0] o, input [16:0] x, input [15:0] d);
        integer n;
        begin
            n = 0;
            // a read that never answers must not pass on stale data
            rd = 16'hxxxx;
            @(posedge ref_clk_i);
            vld <= 1; op_q <= o; ad <= x; dt <= d; cfg <= g;
            @(posedge ref_clk_i);
            vld <= 0;
            // bounded wait: a hung controller ends the op as a mismatch
            while (n < 400) begin
                #1;
                if (rv === 1'b1) rd = rdat;
                if (bsy === 1'b0) n = 999;
                else begin n++; @(posedge ref_clk_i); end
            end
            `CHK(bsy, 1'b0)
        end
    endtask
    task prog(input [16:0] x, input [15:0] d, input w);
        begin
            op(2, x, d);
            if (w) sh[{x[16], x[2:0]}] = ex(x) & d;
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin #200000; bad_count++; finish_test; end
    initial begin
        for (i = 0; i < 16; i++) sh[i] = i * 16'h0101;
        void'($urandom(32'h63d52970));
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1;
        a = {1'b0, 16'($urandom)};
        b = a ^ 17'h10000;
        prog(a, 16'($urandom), 1);
        op(0, a, 0); `CHK(rd, 16'h0080)
        op(3, a, 0); op(0, a, 0); `CHK(rd, ex(a))
        op(6, a, 16'h00d0); op(3, a, 0); op(0, a, 0); `CHK(rd, ex(a))
        $display("program and orphan test done");
        op(1, a ^ 17'h5, 0);
        for (i = 0; i < 8; i++) sh[i] = 16'hffff;
        op(3, a, 0); op(0, a, 0); `CHK(rd, 16'hffff)
        op(0, b, 0); `CHK(rd, ex(b))
        $display("erase test done");
        for (k = 0; k < 3; k++) begin
            g = k == 0 ? 3'b000 : (k == 1 ? 3'b001 : 3'b010);
            prog(b, k == 0 ? 16'h0000 : 16'($urandom), k != 0);
            op(3, b, 0); op(0, b, 0); `CHK(rd, ex(b))
        end
        g = 0;
        $display("boot block test done");
        op(4, 0, 0); op(0, 17'h0, 0); `CHK(rd, {8'h00, MAN})
        op(0, 17'h1, 0); `CHK(rd, {8'h00, DEV})
        op(3, 0, 0); op(5, 17'h1, 0); `CHK(rd, {8'h00, DEV})
        g = 3'b100;
        op(0, a, 0); `CHK(rd, ex(a) & 16'h00ff)
        $display("id and byte test done");
        finish_test;
    end
endmodule
